// [rtl/wdwk_map.vh]
// register map, field positions, reset values and timing counts of the watchdog block
`ifndef WDWK_MAP_VH
`define WDWK_MAP_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define WDWK_ADDR_CTRL    12'h000
`define WDWK_ADDR_WAKE    12'h004
`define WDWK_ADDR_STATUS  12'h008
// ----------------------------------------
// control register fields and reset value
// ----------------------------------------
`define WDWK_KEEP_BIT     7
`define WDWK_SEL_HI       6
`define WDWK_SEL_LO       4
`define WDWK_KEY_HI       3
`define WDWK_KEY_LO       0
`define WDWK_CTRL_RESET   8'h7a
`define WDWK_KEY_DISABLE  4'ha
`define WDWK_WAKE_RESET   8'h00
// ----------------------------------------
// status register fields
// ----------------------------------------
`define WDWK_ST_TO        0
`define WDWK_ST_PDF       1
`define WDWK_ST_HRDY      2
`define WDWK_ST_LRDY      3
`define WDWK_ST_SLEEP     4
`define WDWK_ST_EN        5
// ----------------------------------------
// timing
// ----------------------------------------
`define WDWK_TO_BASE      13
`define WDWK_SYS_DIV      2'd3
`define WDWK_SST_CYCLES   11'd1024
`endif

// [rtl/wdwk_watchdog.v]
// watchdog timer with sleep and idle wake-up handling
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "wdwk_map.vh"

// Function
// - wake on reset, port edge, interrupt, overflow
// - reset wake full; overflow wake watchdog reset
// - pdf cleared by power-up, clear; set by halt
// - halt sets pdf and clears timeout flag
// - per-pin falling edge wake, resume after halt
// - disabled or stack full: resume, keep pending
// - enabled, stack free: normal interrupt response
// - request set before sleep cannot wake
// - one startup timer, high then low crystal
// - first instruction only after high oscillator ready
// - source is sub clock or system/4
// - timeout is two to thirteen plus select
// - control bit 7 keeps system clock in idle
// - disabled only if config off and key 1010
// - power-on key 1010, select 111, keep 0
// - watchdog instructions are no-ops when disabled
// - overflow in ST_RUN resets device, sets timeout flag
// - sleeping overflow resets pc and sp only
// - counter cleared by reset pin, clears, halt
// - config picks single clear or alternating pair
// - system/4 source stops in deep sleep, idle0
module wdwk_watchdog (
    input  wire        clk,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // configuration straps
    input  wire        cfgWdogEnable,
    input  wire        cfgSrcSub,
    input  wire        cfgClrSingle,
    input  wire        cfgSubCrystal,
    // core side, same clock
    input  wire        instrHalt,
    input  wire        idleEnable,
    input  wire        clearWdogSingle,
    input  wire        clearWdogFirst,
    input  wire        clearWdogSecond,
    input  wire [7:0]  intRequest,
    input  wire [7:0]  intEnable,
    input  wire        stackFull,
    // pins and foreign clocks
    input  wire        resetPin_n,
    input  wire [7:0]  portA,
    input  wire        subClock,
    // results
    output reg         fullReset,
    output reg         wdogReset,
    output reg         wakeResume,
    output reg         intRespond,
    output reg         coreHold,
    output reg         sysClkRun,
    output reg         timeoutFlag,
    output reg         powerDownFlag,
    output reg         highOscReady,
    output reg         lowOscReady
);

// ----------------------------------------
// states
// ----------------------------------------
localparam [3:0] ST_RUN   = 4'b0001;
localparam [3:0] ST_SLEEP = 4'b0010;
localparam [3:0] ST_HOSC  = 4'b0100;
localparam [3:0] ST_LOSC  = 4'b1000;

// ----------------------------------------
// declarations
// ----------------------------------------
reg  [7:0]  ctrlReg;
reg  [7:0]  wakeEnable;
reg  [3:0]  state;
reg  [19:0] wdogCount;
reg  [1:0]  sysDiv;
reg         clrLast;
reg  [7:0]  wakeArm;
reg  [10:0] sstCount;
reg         lowPending;
reg         deepSleep;
reg         resetSync1;
reg         resetSync2;
reg  [7:0]  portSync1;
reg  [7:0]  portSync2;
reg  [7:0]  portPrev;
reg         subSync1;
reg         subSync2;
reg         subPrev;
wire        wdogOn;
wire        srcTick;
wire        srcStopped;
wire        overflow;
wire        clearOk;
wire        resetLow;
wire        portWake;
wire        intWake;
wire        apbSetup;
wire        apbWrite;
wire        haltNow;

// ----------------------------------------
// helpers
// ----------------------------------------
// last count of the selected time-out period
function [19:0] lastCount;
    input [2:0] sel;
    begin
        lastCount = (20'h00001 << (`WDWK_TO_BASE + sel)) - 20'h00001;
    end
endfunction

// address decode used by read and write paths
function [1:0] regIndex;
    input [11:0] addr;
    begin
        if (addr == `WDWK_ADDR_CTRL) begin
            regIndex = 2'd0;
        end else if (addr == `WDWK_ADDR_WAKE) begin
            regIndex = 2'd1;
        end else if (addr == `WDWK_ADDR_STATUS) begin
            regIndex = 2'd2;
        end else begin
            regIndex = 2'd3;
        end
    end
endfunction

// ----------------------------------------
// synchronisers for pins and sub clock
// ----------------------------------------
// two flops before any logic looks at a pin
always @(posedge clk) begin
    if (rst) begin
        resetSync1 <= 1'b1;
        resetSync2 <= 1'b1;
        portSync1  <= 8'hff;
        portSync2  <= 8'hff;
        portPrev   <= 8'hff;
        subSync1   <= 1'b0;
        subSync2   <= 1'b0;
        subPrev    <= 1'b0;
    end else begin
        resetSync1 <= resetPin_n;
        resetSync2 <= resetSync1;
        portSync1  <= portA;
        portSync2  <= portSync1;
        portPrev   <= portSync2;
        subSync1   <= subClock;
        subSync2   <= subSync1;
        subPrev    <= subSync2;
    end
end

// ----------------------------------------
// derived conditions
// ----------------------------------------
assign wdogOn = cfgWdogEnable |
                (ctrlReg[`WDWK_KEY_HI:`WDWK_KEY_LO] != `WDWK_KEY_DISABLE);
// system clock stops in sleep and in idle without keep
assign srcStopped = (state == ST_SLEEP) &
                    (~idleEnable | ~ctrlReg[`WDWK_KEEP_BIT]);
assign srcTick = cfgSrcSub ? (subSync2 & ~subPrev)
                           : ((sysDiv == `WDWK_SYS_DIV) & ~srcStopped);
assign overflow = wdogOn & srcTick &
                  (wdogCount == lastCount(ctrlReg[`WDWK_SEL_HI:`WDWK_SEL_LO]));
// single clear, or alternating pair where a repeat does nothing
assign clearOk = wdogOn & (cfgClrSingle ? clearWdogSingle :
                 ((clearWdogFirst & ~clrLast) | (clearWdogSecond & clrLast)));
// halt counts whenever the core is actually running, low crystal start-up included
assign haltNow = instrHalt & ((state == ST_RUN) | (state == ST_LOSC));
assign resetLow = ~resetSync2;
assign portWake = |(wakeEnable & portPrev & ~portSync2);
assign intWake  = |(intRequest & wakeArm);
assign apbSetup = psel & ~penable;
assign apbWrite = psel & penable & pready & pwrite;

// ----------------------------------------
// apb slave, one wait-free access cycle
// ----------------------------------------
// answer is prepared in setup and shown in the access phase
always @(posedge clk) begin
    if (rst) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
    end else begin
        pready  <= apbSetup;
        pslverr <= apbSetup & (regIndex(paddr) == 2'd3);
        if (apbSetup & ~pwrite) begin
            if (regIndex(paddr) == 2'd0) begin
                prdata <= {24'h000000, ctrlReg};
            end else if (regIndex(paddr) == 2'd1) begin
                prdata <= {24'h000000, wakeEnable};
            end else if (regIndex(paddr) == 2'd2) begin
                prdata <= {26'h0000000, wdogOn, (state == ST_SLEEP),
                           lowOscReady, highOscReady, powerDownFlag, timeoutFlag};
            end else begin
                prdata <= 32'h00000000;
            end
        end else begin
            prdata <= 32'h00000000;
        end
    end
end

// register writes take effect at the completing edge
always @(posedge clk) begin
    if (rst) begin
        ctrlReg    <= `WDWK_CTRL_RESET;
        wakeEnable <= `WDWK_WAKE_RESET;
    end else if (apbWrite) begin
        if (regIndex(paddr) == 2'd0) begin
            ctrlReg <= pwdata[7:0];
        end else if (regIndex(paddr) == 2'd1) begin
            wakeEnable <= pwdata[7:0];
        end
    end
end

// ----------------------------------------
// source clock divider and counter
// ----------------------------------------
// system clock divided by four, frozen while the clock is stopped
always @(posedge clk) begin
    if (rst) begin
        sysDiv <= 2'd0;
    end else if (~srcStopped) begin
        sysDiv <= sysDiv + 2'd1;
    end
end

// counter clears on reset pin, clear instruction, halt, overflow
always @(posedge clk) begin
    if (rst) begin
        wdogCount <= 20'h00000;
    end else if (resetLow | clearOk | haltNow) begin
        wdogCount <= 20'h00000;
    end else if (~wdogOn | overflow) begin
        wdogCount <= 20'h00000;
    end else if (srcTick) begin
        wdogCount <= wdogCount + 20'h00001;
    end
end

// alternate clear tracking: low means first is expected
always @(posedge clk) begin
    if (rst) begin
        clrLast <= 1'b0;
    end else if (clearOk & ~cfgClrSingle) begin
        clrLast <= ~clrLast;
    end
end

// ----------------------------------------
// status flags
// ----------------------------------------
// overflow sets timeout flag and wins over the halt clear
always @(posedge clk) begin
    if (rst) begin
        timeoutFlag   <= 1'b0;
        powerDownFlag <= 1'b0;
    end else begin
        if (overflow) begin
            timeoutFlag <= 1'b1;
        end else if (haltNow) begin
            timeoutFlag <= 1'b0;
        end
        if (haltNow) begin
            powerDownFlag <= 1'b1;
        end else if (clearOk) begin
            powerDownFlag <= 1'b0;
        end
    end
end

// ----------------------------------------
// sleep, wake and start-up sequencing
// ----------------------------------------
always @(posedge clk) begin
    if (rst) begin
        state        <= ST_RUN;
        wakeArm      <= 8'h00;
        sstCount     <= 11'd0;
        lowPending   <= 1'b0;
        deepSleep    <= 1'b0;
        fullReset    <= 1'b0;
        wdogReset    <= 1'b0;
        wakeResume   <= 1'b0;
        intRespond   <= 1'b0;
        coreHold     <= 1'b0;
        sysClkRun    <= 1'b1;
        highOscReady <= 1'b1;
        lowOscReady  <= 1'b1;
    end else begin
        fullReset  <= resetLow; // pin low requests reset in every state
        wdogReset  <= 1'b0;
        wakeResume <= 1'b0;
        intRespond <= 1'b0;
        case (state)
            ST_RUN: begin
                if (resetLow) begin
                    fullReset <= 1'b1;
                end else if (overflow) begin
                    fullReset <= 1'b1;
                end else if (instrHalt) begin
                    // only requests clear at entry may wake later
                    wakeArm   <= ~intRequest;
                    deepSleep <= ~idleEnable & ~wdogOn;
                    coreHold  <= 1'b1;
                    sysClkRun <= idleEnable & ctrlReg[`WDWK_KEEP_BIT];
                    if (~idleEnable & ~wdogOn) begin
                        highOscReady <= 1'b0;
                        lowOscReady  <= ~cfgSubCrystal;
                    end
                    state <= ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (resetLow) begin
                    fullReset <= 1'b1;
                    state     <= ST_HOSC;
                end else if (overflow) begin
                    wdogReset <= 1'b1;
                    state     <= ST_HOSC;
                end else if (portWake | intWake) begin
                    wakeResume <= 1'b1;
                    intRespond <= intWake & |(intRequest & wakeArm & intEnable) &
                                  ~stackFull;
                    state      <= ST_HOSC;
                end
                sstCount   <= 11'd0;
                lowPending <= deepSleep & cfgSubCrystal;
            end
            ST_HOSC: begin
                // high crystal start-up first, core held until ready
                if (highOscReady | (sstCount == `WDWK_SST_CYCLES - 11'd1)) begin
                    highOscReady <= 1'b1;
                    coreHold     <= 1'b0;
                    sysClkRun    <= 1'b1;
                    sstCount     <= 11'd0;
                    state        <= lowPending ? ST_LOSC : ST_RUN;
                end else begin
                    sstCount <= sstCount + 11'd1;
                end
            end
            ST_LOSC: begin
                // low crystal reuses the timer, core already running
                if (sstCount == `WDWK_SST_CYCLES - 11'd1) begin
                    lowOscReady <= 1'b1;
                    lowPending  <= 1'b0;
                    state       <= ST_RUN;
                end else begin
                    sstCount <= sstCount + 11'd1;
                end
                if (instrHalt) begin
                    wakeArm   <= ~intRequest;
                    deepSleep <= ~idleEnable & ~wdogOn;
                    coreHold  <= 1'b1;
                    sysClkRun <= idleEnable & ctrlReg[`WDWK_KEEP_BIT];
                    state     <= ST_SLEEP;
                end
            end
            default: begin
                state <= ST_RUN;
            end
        endcase
    end
end

endmodule // wdwk_watchdog

// [dv/wdwk_props.sv]
// concurrent checks on the watchdog block ports
`timescale 1ns/1ps
module wdwk_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        instrHalt,
    input wire logic        resetPin_n,
    input wire logic        fullReset,
    input wire logic        wdogReset,
    input wire logic        wakeResume,
    input wire logic        intRespond,
    input wire logic        coreHold,
    input wire logic        timeoutFlag,
    input wire logic        powerDownFlag
);
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence setupPhase;
        psel && !penable;
    endsequence
    sequence haltRun;
        instrHalt && !coreHold;
    endsequence
    AST_APB_ANSWER: assert property (setupPhase |=> pready) else $error("no ready after setup");
    AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
    AST_READY_ONE: assert property (pready |=> !pready) else $error("ready held too long");
    AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0) else $error("data outside access");
    AST_HALT_PDF: assert property (haltRun |=> powerDownFlag) else $error("halt left pdf low");
    AST_HALT_HOLD: assert property (haltRun |-> ##[1:2] coreHold) else $error("halt did not stop core");
    AST_SLEEP_TO: assert property (wdogReset |-> ##[0:1] (timeoutFlag && powerDownFlag))
        else $error("sleep overflow flags wrong");
    AST_RESPOND: assert property (intRespond |-> wakeResume) else $error("respond without wake");
    AST_PIN_RESET: assert property (!resetPin_n [*4] |-> fullReset) else $error("pin reset lost");
    AST_POWER_ON: assert property (disable iff (1'b0) rst |=> !timeoutFlag && !powerDownFlag)
        else $error("flags set after power-up");
endmodule // wdwk_props

bind wdwk_watchdog wdwk_props u_props (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instrHalt(instrHalt), .resetPin_n(resetPin_n), .fullReset(fullReset),
    .wdogReset(wdogReset), .wakeResume(wakeResume), .intRespond(intRespond),
    .coreHold(coreHold), .timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag)
);

// [dv/wdwk_watchdog_tb_top.sv]
// self-checking bench of the watchdog and wake-up block
`timescale 1ns/1ps
`include "wdwk_map.vh"
module wdwk_watchdog_tb_top;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, resp, got;
    logic        clrOne = 0, clrA = 0, clrB = 0, halt_ = 0, idleEn = 1, stackFull = 0, pin_n = 1;
    logic        cfgWdog = 0, cfgSub = 0, cfgSingle = 1, cfgXtal = 0, subClk = 0;
    logic [7:0]  intReq = 8'h0, intEn = 8'h0, portA = 8'hff;
    logic        fullReset, wdogReset, wakeResume, intRespond, coreHold, sysClkRun;
    logic        timeoutFlag, powerDownFlag, highOscReady, lowOscReady;
    int          n_errors = 0, checked = 0, n;
    // ----------------------------------------
    // clock and design
    // ----------------------------------------
    always #50 clk = ~clk;
    // free-running sub clock, one rising edge every two system clocks
    always @(posedge clk) subClk <= ~subClk;
    wdwk_watchdog u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfgWdogEnable(cfgWdog), .cfgSrcSub(cfgSub), .cfgClrSingle(cfgSingle),
        .cfgSubCrystal(cfgXtal),
        .instrHalt(halt_), .idleEnable(idleEn), .clearWdogSingle(clrOne),
        .clearWdogFirst(clrA), .clearWdogSecond(clrB), .intRequest(intReq),
        .intEnable(intEn), .stackFull(stackFull), .resetPin_n(pin_n), .portA(portA),
        .subClock(subClk), .fullReset(fullReset), .wdogReset(wdogReset),
        .wakeResume(wakeResume), .intRespond(intRespond), .coreHold(coreHold),
        .sysClkRun(sysClkRun), .timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag),
        .highOscReady(highOscReady), .lowOscReady(lowOscReady));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one apb transfer, held until pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            stop_test();
        end
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk); // idle edge so a following call never reassigns psel in this step
    endtask
    // one-cycle instruction pulses
    task halt;
        halt_ <= 1; @(posedge clk); halt_ <= 0; repeat (3) @(posedge clk);
    endtask
    // 0 single clear, 1 first of pair, 2 second of pair
    task clear(input int k);
        if (k == 0) clrOne <= 1;
        else if (k == 1) clrA <= 1;
        else clrB <= 1;
        @(posedge clk);
        clrOne <= 0;
        clrA <= 0;
        clrB <= 0;
        repeat (3) @(posedge clk);
    endtask
    // bounded wait for 0 full reset, 1 watchdog reset, 2 resume, 3 core released, 4 low ready
    task wait_ev(input int sel, input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge clk);
            resp = intRespond;
            if ((sel == 0 && fullReset === 1'b1) || (sel == 1 && wdogReset === 1'b1) ||
                (sel == 2 && wakeResume === 1'b1) || (sel == 3 && coreHold === 1'b0) ||
                (sel == 4 && lowOscReady === 1'b1)) break;
        end
        if (n > lim) begin
            n_errors++;
            stop_test();
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        apb(0, `WDWK_ADDR_CTRL, 0); check(rd, 32'h7a);
        apb(0, `WDWK_ADDR_WAKE, 0); check(rd, 32'h0);
        apb(0, 12'h00c, 0); check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(0, `WDWK_ADDR_STATUS, 0); check(rd[5], 1'b0);
        cfgWdog <= 1;
        apb(0, `WDWK_ADDR_STATUS, 0); check(rd[5], 1'b1);
        cfgWdog <= 0;
        apb(1, `WDWK_ADDR_CTRL, 32'h05);
        apb(0, `WDWK_ADDR_CTRL, 0); check(rd, 32'h05);
        apb(0, `WDWK_ADDR_STATUS, 0); check(rd[5], 1'b1);
        $display("regs done");
    endtask
    task t_overflow;
        clear(0);
        wait_ev(0, 33000);
        check(n >= 32760 && n <= 32776, 1'b1);
        repeat (2) @(posedge clk);
        check(timeoutFlag, 1'b1);
        $display("overflow done");
    endtask
    task t_port_wake;
        int k;
        apb(1, `WDWK_ADDR_WAKE, 32'h01);
        apb(1, `WDWK_ADDR_CTRL, 32'h85);
        cfgSingle <= 0;
        for (k = 0; k < 2; k++) begin
            halt();
            check({timeoutFlag, powerDownFlag, coreHold, sysClkRun}, 4'b0111);
            portA <= 8'hfe;
            wait_ev(2, 20);
            portA <= 8'hff;
            repeat (4) @(posedge clk);
            clear(2 - k);
            check(powerDownFlag, 1'b1);
            clear(1 + k);
            check(powerDownFlag, 1'b0);
        end
        cfgSingle <= 1;
        $display("port wake done");
    endtask
    task t_int;
        int s;
        for (s = 0; s < 3; s++) begin
            stackFull <= (s == 1);
            intEn <= (s == 2) ? 8'h00 : 8'h08;
            intReq <= 8'h04;
            halt();
            got = 0;
            repeat (30) begin
                @(posedge clk);
                if (wakeResume === 1'b1) got = 1;
            end
            check(got, 1'b0);
            intReq <= 8'h0c;
            wait_ev(2, 20);
            check(resp, s == 0);
            intReq <= 8'h0; repeat (4) @(posedge clk);
        end
        $display("interrupt wake done");
    endtask
    task t_sleep_overflow;
        cfgSub <= 1;
        idleEn <= 0;
        halt();
        check(sysClkRun, 1'b0);
        wait_ev(1, 17000);
        check(n >= 16376 && n <= 16392, 1'b1);
        repeat (2) @(posedge clk);
        check({timeoutFlag, powerDownFlag}, 2'b11);
        cfgSub <= 0;
        idleEn <= 1;
        repeat (4) @(posedge clk);
        $display("sleep overflow done");
    endtask
    task t_disabled;
        apb(1, `WDWK_ADDR_CTRL, 32'h8a);
        apb(0, `WDWK_ADDR_STATUS, 0); check(rd[5], 1'b0);
        idleEn <= 0;
        cfgXtal <= 1;
        halt();
        check({highOscReady, lowOscReady, coreHold, sysClkRun}, 4'b0010);
        portA <= 8'hfe; wait_ev(2, 20); portA <= 8'hff;
        wait_ev(3, 1100);
        check(n >= 1020 && n <= 1028, 1'b1);
        check({highOscReady, lowOscReady}, 2'b10);
        wait_ev(4, 1100);
        check(n >= 1020 && n <= 1028, 1'b1);
        idleEn <= 1;
        clear(0);
        check(powerDownFlag, 1'b1);
        $display("disabled done");
    endtask
    task t_pin;
        pin_n <= 0;
        wait_ev(0, 10);
        repeat (4) @(posedge clk);
        pin_n <= 1;
        repeat (4) @(posedge clk);
        check({timeoutFlag, powerDownFlag}, 2'b01);
        $display("reset pin done");
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_regs(); t_overflow(); t_port_wake(); t_int(); t_sleep_overflow(); t_disabled(); t_pin();
        stop_test();
    end
endmodule // wdwk_watchdog_tb_top
